// ### twsbm_pkg.sv
// Constants, offsets and state codes of the two-wire serial bus master.
// Assumes a 200 MHz core clock and a 32-bit classic Wishbone register bus.
package twsbm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CLKSEL = 8'h04;
  localparam logic [7:0] OFF_WTMODE = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RXDATA = 8'h18;
  localparam logic [7:0] OFF_MATCH = 8'h1C;
  localparam logic [7:0] OFF_IRQST = 8'h20;
  localparam logic [7:0] OFF_IRQMSK = 8'h24;

  // Register values and fields
  localparam logic [7:0] MODE_BUS_VAL = 8'h93;
  localparam logic [7:0] MODE_WR_MASK = 8'hBF;
  localparam int MODE_MATCH_BIT = 6;
  localparam logic [3:0] CLKSEL_DIV16 = 4'h8;
  localparam logic [7:0] WT_MODE_VAL = 8'h26;
  localparam int CTRL_START_BIT = 2;
  localparam int CTRL_REL_BIT = 3;
  localparam logic [7:0] RX_IDLE_BYTE = 8'hFF;

  // Transfer types
  localparam logic [1:0] TYPE_ADDR = 2'h0;
  localparam logic [1:0] TYPE_CMD = 2'h1;
  localparam logic [1:0] TYPE_DTX = 2'h2;
  localparam logic [1:0] TYPE_DRX = 2'h3;

  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TOUT = 1;
  localparam int IRQ_LINE = 2;

  // Marker phase steps
  localparam logic [1:0] PRE_LOW = 2'h0;
  localparam logic [1:0] PRE_REL = 2'h1;
  localparam logic [1:0] PRE_CMD = 2'h2;
  localparam logic [1:0] PRE_DROP = 2'h3;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint WT_INTERVAL_PS = 64'd1950000000;
  localparam int WT_TICK_CYC = int'(WT_INTERVAL_PS / CLK_PERIOD_PS);
  localparam logic [2:0] ACK_TIMEOUT_TICKS = 3'h5;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] HALF_DIV16 = 8'h08;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_PRE = 6'b000010,
    ST_BITS = 6'b000100,
    ST_ACKS = 6'b001000,
    ST_AWAIT = 6'b010000,
    ST_BUSYW = 6'b100000
  } twsbm_state_t;

endpackage : twsbm_pkg

// ### twsbm_watch_timer.sv
// Interval tick generator standing in for the watch timer.
// Assumes an enable held steady while ticks are wanted.
`timescale 1ns/1ps
module twsbm_watch_timer #(
  parameter int TICK_CYCLES = twsbm_pkg::WT_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and tick
  input wire logic enable,
  output logic tick
);

  logic [31:0] cnt_r;

  // Restarts from zero whenever disabled, so the first tick is a full period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt_r == 32'(TICK_CYCLES - 1))
    begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule : twsbm_watch_timer

// ### twsbm_master.sv
// Two-wire serial bus master with ack time-out and bus-line self-check.
// Assumes an open-drain data line pulled up outside the chip; the clock line is driven both high and low.
`timescale 1ns/1ps
module twsbm_master #(
  parameter int WT_TICK_CYCLES = twsbm_pkg::WT_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial clock line
  output logic sclkOut,
  // Serial data line, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Interrupt
  output logic irq
);

  twsbm_pkg::twsbm_state_t state_r;
  logic [7:0] mode_r, wtMode_r, txData_r, shift_r, match_r, rxData_r;
  logic [3:0] clkSel_r;
  logic [2:0] irqSt_r, irqMsk_r, irqSet, bitCnt_r, ackCnt_r;
  logic [1:0] type_r, preStep_r;
  logic [7:0] halfCnt_r;
  logic latch_r, rxMode_r, errFlag_r, ackWait_r, matchFlag_r;
  logic busy, modeOk, wtTick, halfTick, finish, irqAny;
  logic wbReq, wrEn, startReq, relReq;

  // Half period of the serial clock for a clock select nibble
  function automatic logic [7:0] halfLen(input logic [3:0] sel);
    if (sel == twsbm_pkg::CLKSEL_DIV16)
      halfLen = twsbm_pkg::HALF_DIV16;
    else
      halfLen = twsbm_pkg::HALF_DIV16 << 1;
  endfunction : halfLen

  assign busy = (state_r != twsbm_pkg::ST_IDLE);
  assign modeOk = ((mode_r & twsbm_pkg::MODE_WR_MASK)
                   == twsbm_pkg::MODE_BUS_VAL);
  assign wbReq = cyc_i && stb_i && !ack_o;
  assign wrEn = wbReq && we_i && sel_i[0];
  assign startReq = wrEn && (adr_i == twsbm_pkg::OFF_CTRL)
                    && dat_i[twsbm_pkg::CTRL_START_BIT]
                    && !busy && modeOk && latch_r;
  assign relReq = wrEn && (adr_i == twsbm_pkg::OFF_CTRL)
                  && dat_i[twsbm_pkg::CTRL_REL_BIT];
  assign halfTick = busy && (halfCnt_r == 8'h00);
  assign finish = (state_r == twsbm_pkg::ST_BUSYW) && halfTick
                  && !sdaOe && sdaIn;
  assign irqAny = |(irqSt_r & irqMsk_r);

  twsbm_watch_timer #(
    .TICK_CYCLES(WT_TICK_CYCLES)
  ) u_wt (
    .clk(clk),
    .rst(rst),
    .enable(wtMode_r == twsbm_pkg::WT_MODE_VAL),
    .tick(wtTick)
  );

  // Register writes; mode and clock are frozen during a transfer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= 8'h00;
      clkSel_r <= 4'h0;
      wtMode_r <= 8'h00;
      txData_r <= 8'h00;
      type_r <= twsbm_pkg::TYPE_ADDR;
      irqMsk_r <= 3'h0;
      latch_r <= 1'b0;
    end
    else
    begin
      if (wrEn && !busy)
      begin
        unique case (adr_i)
          twsbm_pkg::OFF_MODE: mode_r <= dat_i[7:0];
          twsbm_pkg::OFF_CLKSEL: clkSel_r <= dat_i[3:0];
          twsbm_pkg::OFF_WTMODE: wtMode_r <= dat_i[7:0];
          twsbm_pkg::OFF_TXDATA: txData_r <= dat_i[7:0];
          twsbm_pkg::OFF_CTRL: type_r <= dat_i[1:0];
          default: ;
        endcase
      end
      if (wrEn && adr_i == twsbm_pkg::OFF_IRQMSK)
        irqMsk_r <= dat_i[2:0];
      if (relReq)
        latch_r <= 1'b1;
    end
  end

  // Bus answers one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= wbReq;
      dat_o <= 32'h0;
      if (wbReq && !we_i)
      begin
        unique case (adr_i)
          twsbm_pkg::OFF_MODE:
            dat_o[7:0] <= {mode_r[7], matchFlag_r, mode_r[5:0]};
          twsbm_pkg::OFF_CLKSEL: dat_o[3:0] <= clkSel_r;
          twsbm_pkg::OFF_WTMODE: dat_o[7:0] <= wtMode_r;
          twsbm_pkg::OFF_TXDATA: dat_o[7:0] <= txData_r;
          twsbm_pkg::OFF_CTRL: dat_o[1:0] <= type_r;
          twsbm_pkg::OFF_STATUS:
            dat_o[4:0] <= {latch_r, matchFlag_r, ackWait_r, errFlag_r,
                           busy};
          twsbm_pkg::OFF_RXDATA: dat_o[7:0] <= rxData_r;
          twsbm_pkg::OFF_MATCH: dat_o[7:0] <= match_r;
          twsbm_pkg::OFF_IRQST: dat_o[2:0] <= irqSt_r;
          twsbm_pkg::OFF_IRQMSK: dat_o[2:0] <= irqMsk_r;
          default: ;
        endcase
      end
    end
  end

  // Serial clock divider, runs only during a transfer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      halfCnt_r <= 8'h00;
    else if (!busy || halfTick)
      halfCnt_r <= halfLen(clkSel_r) - 8'h01;
    else
      halfCnt_r <= halfCnt_r - 8'h01;
  end

  // Transfer sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= twsbm_pkg::ST_IDLE;
      sclkOut <= 1'b1;
      sdaOe <= 1'b0;
      shift_r <= 8'h00;
      match_r <= 8'h00;
      rxData_r <= 8'h00;
      bitCnt_r <= 3'h0;
      ackCnt_r <= 3'h0;
      preStep_r <= twsbm_pkg::PRE_LOW;
      rxMode_r <= 1'b0;
      errFlag_r <= 1'b0;
      ackWait_r <= 1'b0;
      matchFlag_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        twsbm_pkg::ST_IDLE:
        begin
          sdaOe <= modeOk && !latch_r;
          sclkOut <= 1'b1;
          if (startReq)
          begin
            rxMode_r <= (dat_i[1:0] == twsbm_pkg::TYPE_DRX);
            errFlag_r <= 1'b0;
            bitCnt_r <= 3'h0;
            if (dat_i[1:0] == twsbm_pkg::TYPE_DRX)
            begin
              shift_r <= twsbm_pkg::RX_IDLE_BYTE;
              match_r <= twsbm_pkg::RX_IDLE_BYTE;
            end
            else
            begin
              shift_r <= txData_r;
              match_r <= txData_r;
            end
            if (dat_i[1:0] == twsbm_pkg::TYPE_ADDR)
            begin
              preStep_r <= twsbm_pkg::PRE_LOW;
              sdaOe <= 1'b1;
              state_r <= twsbm_pkg::ST_PRE;
            end
            else if (dat_i[1:0] == twsbm_pkg::TYPE_CMD)
            begin
              preStep_r <= twsbm_pkg::PRE_CMD;
              sdaOe <= 1'b1;
              state_r <= twsbm_pkg::ST_PRE;
            end
            else
            begin
              sclkOut <= 1'b0;
              sdaOe <= (dat_i[1:0] == twsbm_pkg::TYPE_DTX) && !txData_r[7];
              state_r <= twsbm_pkg::ST_BITS;
            end
          end
        end
        twsbm_pkg::ST_PRE:
          if (halfTick)
          begin
            unique case (preStep_r)
              twsbm_pkg::PRE_LOW:
              begin
                sdaOe <= 1'b0;
                preStep_r <= twsbm_pkg::PRE_REL;
              end
              twsbm_pkg::PRE_REL:
                if (sdaIn)
                begin
                  sdaOe <= 1'b1;
                  preStep_r <= twsbm_pkg::PRE_CMD;
                end
              twsbm_pkg::PRE_CMD:
              begin
                sdaOe <= 1'b1;
                sclkOut <= 1'b0;
                preStep_r <= twsbm_pkg::PRE_DROP;
              end
              twsbm_pkg::PRE_DROP:
              begin
                sdaOe <= !rxMode_r && !shift_r[7];
                state_r <= twsbm_pkg::ST_BITS;
              end
            endcase
          end
        twsbm_pkg::ST_BITS:
          if (halfTick)
          begin
            if (!sclkOut)
              sclkOut <= 1'b1;
            else
            begin
              // Line is read back, so a stuck bit shows up as a mismatch
              shift_r <= {shift_r[6:0], sdaIn};
              sclkOut <= 1'b0;
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == twsbm_pkg::LAST_BIT)
              begin
                sdaOe <= rxMode_r;
                state_r <= twsbm_pkg::ST_ACKS;
              end
              else
                sdaOe <= !rxMode_r && !shift_r[6];
            end
          end
        twsbm_pkg::ST_ACKS:
          if (halfTick)
          begin
            if (!sclkOut)
              sclkOut <= 1'b1;
            else
            begin
              sclkOut <= 1'b0;
              sdaOe <= 1'b0;
              if (!rxMode_r && sdaIn)
              begin
                ackCnt_r <= twsbm_pkg::ACK_TIMEOUT_TICKS;
                ackWait_r <= 1'b1;
                state_r <= twsbm_pkg::ST_AWAIT;
              end
              else
                state_r <= twsbm_pkg::ST_BUSYW;
            end
          end
        twsbm_pkg::ST_AWAIT:
          if (!sdaIn)
          begin
            ackWait_r <= 1'b0;
            state_r <= twsbm_pkg::ST_BUSYW;
          end
          else if (wtTick)
          begin
            ackCnt_r <= ackCnt_r - 3'h1;
            if (ackCnt_r == 3'h1)
            begin
              sdaOe <= 1'b1;
              errFlag_r <= 1'b1;
              ackWait_r <= 1'b0;
              state_r <= twsbm_pkg::ST_BUSYW;
            end
          end
        twsbm_pkg::ST_BUSYW:
          if (halfTick)
          begin
            if (sdaOe)
              sdaOe <= 1'b0;
            else if (sdaIn)
            begin
              // Slave busy keeps the line low; wait it out
              rxData_r <= shift_r;
              matchFlag_r <= (shift_r == match_r);
              if (!rxMode_r && shift_r != match_r)
                errFlag_r <= 1'b1;
              state_r <= twsbm_pkg::ST_IDLE;
            end
          end
        default:
          state_r <= twsbm_pkg::ST_IDLE;
      endcase
    end
  end

  // Interrupt events; a new event beats a same-cycle clear
  assign irqSet[twsbm_pkg::IRQ_DONE] = finish;
  assign irqSet[twsbm_pkg::IRQ_TOUT] = (state_r == twsbm_pkg::ST_AWAIT)
                                       && sdaIn && wtTick
                                       && (ackCnt_r == 3'h1);
  assign irqSet[twsbm_pkg::IRQ_LINE] = finish && !rxMode_r
                                       && (shift_r != match_r);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqSt_r <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wrEn && adr_i == twsbm_pkg::OFF_IRQST)
        irqSt_r <= (irqSt_r & ~dat_i[2:0]) | irqSet;
      else
        irqSt_r <= irqSt_r | irqSet;
      irq <= irqAny;
    end
  end

  // Data output latch only ever pulls low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_noAckTick;
    state_r == twsbm_pkg::ST_AWAIT && sdaIn && wtTick && ackCnt_r == 3'h1;
  endsequence
  sequence s_riseReq;
    state_r == twsbm_pkg::ST_BITS && halfTick && !sclkOut;
  endsequence

  a_timeout_ack_out: assert property (s_noAckTick |=> sdaOe && errFlag_r
    && state_r == twsbm_pkg::ST_BUSYW)
    else $error("timeout did not drive ack and flag error");
  a_timeout_ack_len: assert property (s_noAckTick |-> ##[2:18] !sdaOe)
    else $error("master ack not released after one half period");
  a_match_flag_end: assert property (finish |=> matchFlag_r ==
    ($past(shift_r) == $past(match_r)))
    else $error("match flag disagrees with compared bytes");
  a_busy_hold_wait: assert property (state_r == twsbm_pkg::ST_BUSYW
    && !sdaIn && !sdaOe |=> state_r == twsbm_pkg::ST_BUSYW)
    else $error("transfer ended while slave busy");
  a_rx_master_ack: assert property (state_r == twsbm_pkg::ST_ACKS
    && rxMode_r |-> sdaOe)
    else $error("master not acking received byte");
  a_start_load_both: assert property (startReq && dat_i[1:0] !=
    twsbm_pkg::TYPE_DRX |=> shift_r == match_r
    && match_r == $past(txData_r))
    else $error("outgoing byte not loaded in both registers");
  a_sclk_rise_bit: assert property (s_riseReq |=> sclkOut ##1 sclkOut)
    else $error("serial clock did not rise for a bit");
  a_wt_config_tick: assert property (wtTick |->
    wtMode_r == twsbm_pkg::WT_MODE_VAL)
    else $error("watch tick without interval setting");
  a_ack_count_range: assert property (state_r == twsbm_pkg::ST_AWAIT |->
    ackCnt_r >= 3'h1 && ackCnt_r <= twsbm_pkg::ACK_TIMEOUT_TICKS)
    else $error("ack wait count out of range");
  a_mode_gate_busy: assert property ($rose(busy) |-> $past(modeOk)
    && $past(latch_r))
    else $error("transfer started outside bus mode or latch low");
  a_irq_level_out: assert property (##1 irq == $past(irqAny))
    else $error("interrupt output not following masked status");

endmodule : twsbm_master

// ### twsbm_slave_model.sv
// Behavioural slave on the two-wire bus: acks, returns bytes, holds busy.
// Assumes a pulled-up data line and a clock line driven by the master.
`timescale 1ns/1ps
module twsbm_slave_model #(
  parameter int BUSY_CYC = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus lines
  input wire logic sclk,
  input wire logic sdaLine,
  output logic sdaPull,
  // Test controls
  input wire logic ackEn,
  input wire logic jamLast,
  input wire logic rxMode,
  input wire logic [7:0] rxByte,
  output logic [7:0] gotByte
);
  logic sclkQ;
  logic [3:0] cnt;
  int hold;

  // Edges seen on clk, so the model reacts one cycle late like real logic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclkQ <= 1'b1;
      cnt <= 4'h0;
      hold <= 0;
      sdaPull <= 1'b0;
      gotByte <= 8'h00;
    end
    else
    begin
      sclkQ <= sclk;
      if (sclkQ && !sclk)
      begin
        cnt <= cnt + 4'h1;
        if (cnt < 4'h8)
          sdaPull <= rxMode ? ~rxByte[3'h7 - cnt[2:0]]
                            : (jamLast && cnt == 4'h7);
        else
          sdaPull <= ackEn && !rxMode;
      end
      if (!sclkQ && sclk && cnt != 4'h0 && cnt < 4'h9)
        gotByte <= {gotByte[6:0], sdaLine};
      if (!sclkQ && sclk && cnt == 4'h9)
        hold <= BUSY_CYC;
      else if (hold > 1)
        hold <= hold - 1;
      else if (hold == 1)
      begin
        // Ack stretched into busy, then released to the pull-up
        sdaPull <= 1'b0;
        cnt <= 4'h0;
        hold <= 0;
      end
    end
  end
endmodule : twsbm_slave_model

// ### twsbm_master_tb_top.sv
// Self-checking bench of the two-wire bus master over Wishbone.
// Assumes the slave model on a pulled-up line; short watch tick.
`timescale 1ns/1ps
module twsbm_master_tb_top;
  localparam int TICKS = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cycI = 1'b0;
  logic stbI = 1'b0;
  logic weI = 1'b0;
  logic [7:0] adrI = 8'h00;
  logic [3:0] selI = 4'h0;
  logic [31:0] datI = 32'h0;
  logic [31:0] datO;
  logic ackO, sclkOut, sdaOut, sdaOe, irq, slvPull;
  logic ackEn = 1'b1;
  logic jamLast = 1'b0;
  logic rxMode = 1'b0;
  logic [7:0] rxByte = 8'h3C;
  logic [7:0] gotByte;
  logic [31:0] rdData;
  logic sclkQ = 1'b1;
  logic [7:0] txb [4] = '{8'hC3, 8'h5A, 8'hA5, 8'hFF};
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int gap = 0;
  int lastGap = 0;
  int dur = 0;
  int durAck = 0;
  logic [31:0] expB;
  // Open-drain line: low if either party pulls
  wire sdaLine = ~((sdaOe & ~sdaOut) | slvPull);

  always #2.5 clk = ~clk;

  twsbm_master #(.WT_TICK_CYCLES(TICKS)) dut_u (.clk(clk), .rst(rst),
    .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI), .sel_i(selI),
    .dat_i(datI), .dat_o(datO), .ack_o(ackO), .sclkOut(sclkOut),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));

  twsbm_slave_model slave_u (.clk(clk), .rst(rst), .sclk(sclkOut),
    .sdaLine(sdaLine), .sdaPull(slvPull), .ackEn(ackEn), .jamLast(jamLast),
    .rxMode(rxMode), .rxByte(rxByte), .gotByte(gotByte));

  task automatic complete_run();
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Watchdog and serial clock fall spacing
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    sclkQ <= sclkOut;
    gap <= (sclkQ && !sclkOut) ? 1 : gap + 1;
    if (sclkQ && !sclkOut)
      lastGap <= gap;
    if (cycles == 60000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp)
    begin
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      err_count++;
    end
  endtask : check

  // Hold the request until ack is sampled high, then release
  task automatic wbXfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clk);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= we;
    adrI <= a;
    datI <= d;
    selI <= 4'hF;
    do @(posedge clk); while (ackO !== 1'b1);
    rdData = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    weI <= 1'b0;
  endtask : wbXfer

  task automatic regCheck(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp, input string what);
    wbXfer(1'b0, a, 32'h0);
    check(rdData & m, exp, what);
  endtask : regCheck

  task automatic runXfer(input logic [1:0] ty, input logic [7:0] b);
    int t0;
    int n;
    wbXfer(1'b1, twsbm_pkg::OFF_TXDATA, {24'h0, b});
    wbXfer(1'b1, twsbm_pkg::OFF_CTRL, {29'h0, 1'b1, ty});
    t0 = cycles;
    n = 0;
    do
    begin
      wbXfer(1'b0, twsbm_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    while (rdData[0] !== 1'b0 && n < 2000);
    check({31'h0, rdData[0]}, 32'h0, "busy end");
    dur = cycles - t0;
  endtask : runXfer

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({28'h0, sclkOut, sdaOe, irq, ackO}, 32'h8, "reset pins");
    regCheck(twsbm_pkg::OFF_MODE, 32'hFF, 32'h0, "mode reset");
    wbXfer(1'b1, twsbm_pkg::OFF_MODE, 32'h93);
    wbXfer(1'b1, twsbm_pkg::OFF_CLKSEL, 32'h8);
    wbXfer(1'b1, twsbm_pkg::OFF_WTMODE, 32'h26);
    wbXfer(1'b1, twsbm_pkg::OFF_IRQMSK, 32'h7);
    regCheck(twsbm_pkg::OFF_MODE, 32'hBF, 32'h93, "mode");
    check({31'h0, sdaOe}, 32'h1, "latch low");
    wbXfer(1'b1, twsbm_pkg::OFF_CTRL, 32'h8);
    @(posedge clk);
    check({31'h0, sdaOe}, 32'h0, "latch high");
    regCheck(twsbm_pkg::OFF_STATUS, 32'h10, 32'h10, "latch flag");
    // Every transfer type, each acked
    for (int i = 0; i < 4; i++)
    begin
      rxMode <= (i == 3);
      runXfer(2'(i), txb[i]);
      if (i == 2)
        durAck = dur;
      check({31'h0, irq}, 32'h1, "done irq");
      regCheck(twsbm_pkg::OFF_IRQST, 32'h7, 32'h1, "irq status");
      wbXfer(1'b1, twsbm_pkg::OFF_IRQST, 32'h7);
      expB = (i == 3) ? 32'h3C : {24'h0, txb[i]};
      regCheck(twsbm_pkg::OFF_RXDATA, 32'hFF, expB, "readback");
      regCheck(twsbm_pkg::OFF_MATCH, 32'hFF, {24'h0, txb[i]}, "match");
      expB = (i == 3) ? 32'h0 : 32'h40;
      regCheck(twsbm_pkg::OFF_MODE, 32'h40, expB, "flag");
      regCheck(twsbm_pkg::OFF_STATUS, 32'h7, 32'h0, "status");
      if (i < 3)
        check({24'h0, gotByte}, {24'h0, txb[i]}, "wire byte");
      check(lastGap, 16, "sclk period");
      check({31'h0, irq}, 32'h0, "irq cleared");
    end
    // No acknowledge: time-out ends the transfer
    rxMode <= 1'b0;
    ackEn <= 1'b0;
    runXfer(twsbm_pkg::TYPE_DTX, 8'h5A);
    // Ack wait of five ticks minus the slave's own busy hold
    check({31'h0, dur >= durAck + 5 * TICKS / 2}, 32'h1, "tout min");
    check({31'h0, dur <= durAck + 4 * TICKS}, 32'h1, "tout max");
    regCheck(twsbm_pkg::OFF_IRQST, 32'h7, 32'h3, "tout irq");
    regCheck(twsbm_pkg::OFF_STATUS, 32'h2, 32'h2, "error flag");
    wbXfer(1'b1, twsbm_pkg::OFF_IRQMSK, 32'h0);
    wbXfer(1'b0, twsbm_pkg::OFF_MODE, 32'h0);
    check({31'h0, irq}, 32'h0, "masked");
    wbXfer(1'b1, twsbm_pkg::OFF_IRQMSK, 32'h7);
    wbXfer(1'b0, twsbm_pkg::OFF_MODE, 32'h0);
    check({31'h0, irq}, 32'h1, "unmasked");
    wbXfer(1'b1, twsbm_pkg::OFF_IRQST, 32'h7);
    // Line held low on the last bit: readback differs
    ackEn <= 1'b1;
    jamLast <= 1'b1;
    runXfer(twsbm_pkg::TYPE_DTX, 8'hFF);
    regCheck(twsbm_pkg::OFF_RXDATA, 32'hFF, 32'hFE, "jam readback");
    regCheck(twsbm_pkg::OFF_MODE, 32'h40, 32'h0, "jam flag");
    regCheck(twsbm_pkg::OFF_IRQST, 32'h7, 32'h5, "line irq");
    regCheck(twsbm_pkg::OFF_STATUS, 32'h2, 32'h2, "line error");
    // Any other clock select gives the slower serial clock
    jamLast <= 1'b0;
    wbXfer(1'b1, twsbm_pkg::OFF_CLKSEL, 32'h0);
    runXfer(twsbm_pkg::TYPE_CMD, 8'h96);
    check(lastGap, 32, "slow sclk");
    regCheck(twsbm_pkg::OFF_RXDATA, 32'hFF, 32'h96, "slow readback");
    regCheck(8'h30, 32'hFFFFFFFF, 32'h0, "unmapped");
    complete_run();
  end
endmodule : twsbm_master_tb_top
